// *** verilog/cbs_consts.svh ***
// constants of the cell balance sequencer
`ifndef CBS_CONSTS_SVH
`define CBS_CONSTS_SVH

// ****************************************
// register offsets
// ****************************************
`define CBS_A_SETUP    6'h01
`define CBS_A_PATTERN  6'h02
`define CBS_A_WDBT     6'h03
`define CBS_A_DEVSET   6'h04
`define CBS_A_ACTIVE   6'h05
`define CBS_A_VAL_LO   6'h20
`define CBS_A_VAL_HI   6'h37

// ****************************************
// field positions and codes
// ****************************************
`define CBS_F_MODE     0
`define CBS_F_PTR      2
`define CBS_F_WAIT     6
`define CBS_F_RUN      10
`define CBS_F_BTM      7
`define CBS_F_EOB      0
`define CBS_F_WATCHDOG_TIMEOUT_FLAG     1
`define CBS_MODE_MAN   2'h1
`define CBS_MODE_TIMED 2'h2
`define CBS_MODE_AUTO  2'h3
`define CBS_FIRST_LOC  4'h1
`define CBS_LAST_LOC   4'hc
`define CBS_RESET_ALL  '0

// ****************************************
// timing
// ****************************************
`define CBS_UNIT_S     20
`define CBS_CLK_HZ     25000000
`define CBS_TICK_CYC   (`CBS_UNIT_S * `CBS_CLK_HZ)

`endif

// *** verilog/cbs_pkg.sv ***
// types of the cell balance sequencer
package cbs_pkg;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_ON,
    PH_SCAN,
    PH_WAIT
  } cbs_phase_e;

  typedef struct packed {
    cbs_phase_e        phase;
    logic [1:0]        mode;
    logic [3:0]        ptr;
    logic [3:0]        wt;
    logic              run;
    logic [6:0]        btm;
    logic [6:0]        wdt;
    logic              end_of_balance_flag;
    logic              watchdog_timeout_flag;
    logic              sleep;
    logic [12:0][11:0] pat;
    logic [6:0]        cnt;
    logic [3:0]        apt;
    logic [11:0]       mask;
    logic [11:0]       cb;
    logic              scan_req;
    logic [13:0]       rdata;
  } cbs_main_s;

  typedef struct packed {
    logic [31:0] cnt;
  } cbs_tick_s;

  typedef struct packed {
    logic [11:0][27:0] val;
  } cbs_val_s;

endpackage : cbs_pkg

// *** verilog/cbs_tick.sv ***
// slow tick, one pulse per on-time unit
`include "cbs_consts.svh"
module cbs_tick #(
  parameter int unsigned TICK_CYC = `CBS_TICK_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic en_i,
  input  wire logic clr_i,
  output logic      tick_o
);
  cbs_pkg::cbs_tick_s s;
  cbs_pkg::cbs_tick_s n;

  assign tick_o = en_i && (s.cnt == 32'(TICK_CYC - 1));

  always_comb begin
    n = s;
    if (clr_i || !en_i || tick_o) begin
      n.cnt = 32'h0;
    end else begin
      n.cnt = s.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= `CBS_RESET_ALL;
    end else if (ce_i) begin
      s <= n;
    end
  end
endmodule : cbs_tick

// *** verilog/cbs_values.sv ***
// remaining charge values, one per cell
`include "cbs_consts.svh"
module cbs_values (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wr_i,
  input  wire logic [5:0]  addr_i,
  input  wire logic [13:0] wdata_i,
  input  wire logic        meas_valid_i,
  input  wire logic [3:0]  meas_cell_i,
  input  wire logic [13:0] meas_data_i,
  input  wire logic [11:0] sub_mask_i,
  output logic [13:0]      rdata_o,
  output logic [11:0]      nz_o
);
  cbs_pkg::cbs_val_s s;
  cbs_pkg::cbs_val_s n;
  logic [5:0]        off;
  logic              hit;
  logic [11:0][27:0] less;

  assign off = addr_i - `CBS_A_VAL_LO;
  assign hit = (addr_i >= `CBS_A_VAL_LO) && (addr_i <= `CBS_A_VAL_HI);
  assign rdata_o = !hit ? 14'h0 :
                   off[0] ? s.val[off[4:1]][27:14] :
                   s.val[off[4:1]][13:0];

  // ****************************************
  // per cell: saturating decrement
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 12; gi++) begin : g_cell
      assign nz_o[gi] = (s.val[gi] != 28'h0);
      assign less[gi] =
        (s.val[gi] > {14'h0, meas_data_i}) ?
        s.val[gi] - {14'h0, meas_data_i} : 28'h0;
    end
  endgenerate

  always_comb begin
    n = s;
    if (meas_valid_i && (meas_cell_i < 4'hc)) begin
      if (sub_mask_i[meas_cell_i]) begin
        n.val[meas_cell_i] = less[meas_cell_i];
      end
    end
    if (wr_i && hit) begin
      if (off[0]) begin
        n.val[off[4:1]][27:14] = wdata_i;
      end else begin
        n.val[off[4:1]][13:0] = wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= `CBS_RESET_ALL;
    end else if (ce_i) begin
      s <= n;
    end
  end
endmodule : cbs_values

// *** verilog/cbs_seq.sv ***
// cell balance sequencer: timed and automatic balancing
`include "cbs_consts.svh"

module cbs_seq #(
  parameter int unsigned TICK_CYC = `CBS_TICK_CYC
) (
  input  wire logic        MCLK_I,
  input  wire logic        RST_I,
  input  wire logic        CE_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  input  wire logic [5:0]  ADDR_I,
  input  wire logic [13:0] WDATA_I,
  input  wire logic        CMD_EN_I,
  input  wire logic        CMD_INH_I,
  input  wire logic        CMD_SLEEP_I,
  input  wire logic        CMD_WAKE_I,
  input  wire logic        WDT_EXP_I,
  input  wire logic        SCAN_DONE_I,
  input  wire logic        MEAS_VALID_I,
  input  wire logic [3:0]  MEAS_CELL_I,
  input  wire logic [13:0] MEAS_DATA_I,
  output logic [11:0]      CB_O,
  output logic             SCAN_REQ_O,
  output logic             SLEEP_O,
  output logic [13:0]      RDATA_O
);

  // ****************************************
  // state and helpers
  // ****************************************
  cbs_pkg::cbs_main_s s;
  cbs_pkg::cbs_main_s n;
  logic               tick;
  logic               tick_en;
  logic               tick_clr;
  logic [13:0]        val_rdata;
  logic [11:0]        nz;
  logic [11:0]        sub_mask;
  logic               start;
  logic [6:0]         cnt_inc;
  logic [3:0]         apt_inc;
  logic               timed;
  logic               auto_m;

  assign timed   = (s.mode == `CBS_MODE_TIMED);
  assign auto_m  = (s.mode == `CBS_MODE_AUTO);
  assign cnt_inc = s.cnt + 7'h01;
  assign apt_inc = s.apt + 4'h1;

  // timed keeps counting asleep, auto freezes
  assign tick_en = s.run &&
                   ((s.phase == cbs_pkg::PH_ON) ||
                    (s.phase == cbs_pkg::PH_WAIT)) &&
                   (timed || !s.sleep);

  // only cells driven in the last interval take measurements
  assign sub_mask = (s.phase == cbs_pkg::PH_SCAN) ?
                    s.mask : 12'h0;

  assign CB_O       = s.cb;
  assign SCAN_REQ_O = s.scan_req;
  assign SLEEP_O    = s.sleep;
  assign RDATA_O    = s.rdata;

  // ****************************************
  // sub blocks
  // ****************************************
  cbs_tick #(
    .TICK_CYC (TICK_CYC)
  ) u_tick (
    .clk_i  (MCLK_I),
    .rst_i  (RST_I),
    .ce_i   (CE_I),
    .en_i   (tick_en),
    .clr_i  (tick_clr),
    .tick_o (tick)
  );

  cbs_values u_values (
    .clk_i        (MCLK_I),
    .rst_i        (RST_I),
    .ce_i         (CE_I),
    .wr_i         (WR_I),
    .addr_i       (ADDR_I),
    .wdata_i      (WDATA_I),
    .meas_valid_i (MEAS_VALID_I),
    .meas_cell_i  (MEAS_CELL_I),
    .meas_data_i  (MEAS_DATA_I),
    .sub_mask_i   (sub_mask),
    .rdata_o      (val_rdata),
    .nz_o         (nz)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n          = s;
    start      = 1'b0;
    tick_clr   = 1'b0;
    n.scan_req = 1'b0;

    // register writes
    if (WR_I) begin
      case (ADDR_I)
        `CBS_A_SETUP: begin
          n.mode = WDATA_I[`CBS_F_MODE +: 2];
          n.ptr  = WDATA_I[`CBS_F_PTR +: 4];
          n.wt   = WDATA_I[`CBS_F_WAIT +: 4];
          n.run  = WDATA_I[`CBS_F_RUN];
          start  = WDATA_I[`CBS_F_RUN] && !s.run;
        end
        `CBS_A_PATTERN: begin
          if (s.ptr <= `CBS_LAST_LOC) begin
            n.pat[s.ptr] = WDATA_I[11:0];
          end
        end
        `CBS_A_WDBT: begin
          n.btm = WDATA_I[`CBS_F_BTM +: 7];
          n.wdt = WDATA_I[6:0];
        end
        `CBS_A_DEVSET: begin
          // writing zero clears a flag
          n.end_of_balance_flag  = s.end_of_balance_flag && WDATA_I[`CBS_F_EOB];
          n.watchdog_timeout_flag = s.watchdog_timeout_flag && WDATA_I[`CBS_F_WATCHDOG_TIMEOUT_FLAG];
        end
        default: begin
        end
      endcase
    end

    // register reads, answer one cycle later
    if (RD_I) begin
      case (ADDR_I)
        `CBS_A_SETUP: begin
          n.rdata = {3'h0, s.run, s.wt, s.ptr, s.mode};
        end
        `CBS_A_PATTERN: begin
          n.rdata = (s.ptr <= `CBS_LAST_LOC) ?
                    {2'h0, s.pat[s.ptr]} : 14'h0;
        end
        `CBS_A_WDBT: begin
          n.rdata = {s.btm, s.wdt};
        end
        `CBS_A_DEVSET: begin
          n.rdata = {12'h0, s.watchdog_timeout_flag, s.end_of_balance_flag};
        end
        `CBS_A_ACTIVE: begin
          n.rdata = {2'h0, s.cb};
        end
        default: begin
          n.rdata = val_rdata;
        end
      endcase
    end

    // commands, inhibit wins over enable
    if (CMD_EN_I) begin
      n.run = 1'b1;
      start = 1'b1;
    end
    if (CMD_INH_I) begin
      n.run = 1'b0;
      start = 1'b0;
    end

    // sleep, wake and watchdog
    if (CMD_WAKE_I) begin
      n.sleep = 1'b0;
    end
    if (CMD_SLEEP_I) begin
      n.sleep = 1'b1;
    end
    if (WDT_EXP_I && (s.wdt != 7'h0)) begin
      n.sleep = 1'b1;
      n.watchdog_timeout_flag  = 1'b1;
    end

    // ****************************************
    // sequencing
    // ****************************************
    if (!n.run) begin
      n.phase  = cbs_pkg::PH_IDLE;
      n.cnt    = 7'h0;
      tick_clr = 1'b1;
    end else if (start) begin
      n.phase  = cbs_pkg::PH_ON;
      n.cnt    = 7'h0;
      n.apt    = `CBS_FIRST_LOC;
      tick_clr = 1'b1;
    end else begin
      case (s.phase)
        cbs_pkg::PH_ON: begin
          if (tick) begin
            n.cnt = cnt_inc;
          end
          if (timed) begin
            if ((s.btm != 7'h0) && tick && (cnt_inc == s.btm)) begin
              n.end_of_balance_flag   = 1'b1;
              n.run   = 1'b0;
              n.phase = cbs_pkg::PH_IDLE;
              n.cnt   = 7'h0;
            end
          end else if (auto_m && !s.sleep) begin
            if ((s.btm == 7'h0) ||
                (tick && (cnt_inc == s.btm))) begin
              n.phase    = cbs_pkg::PH_SCAN;
              n.scan_req = 1'b1;
              n.mask     = s.pat[s.apt] & nz;
              n.cnt      = 7'h0;
              tick_clr   = 1'b1;
            end
          end
        end
        cbs_pkg::PH_SCAN: begin
          if (SCAN_DONE_I) begin
            n.phase  = cbs_pkg::PH_WAIT;
            n.cnt    = 7'h0;
            tick_clr = 1'b1;
          end
        end
        cbs_pkg::PH_WAIT: begin
          if (tick) begin
            n.cnt = cnt_inc;
          end
          if ((s.wt == 4'h0) ||
              (tick && (cnt_inc == {3'h0, s.wt}))) begin
            n.phase  = cbs_pkg::PH_ON;
            n.cnt    = 7'h0;
            tick_clr = 1'b1;
            if ((s.apt >= `CBS_LAST_LOC) ||
                (s.pat[apt_inc] == 12'h0)) begin
              n.apt = `CBS_FIRST_LOC;
            end else begin
              n.apt = apt_inc;
            end
          end
        end
        default: begin
          n.phase = cbs_pkg::PH_IDLE;
        end
      endcase

      // all values spent ends automatic balancing
      if (auto_m && (nz == 12'h0) &&
          (s.phase != cbs_pkg::PH_SCAN)) begin
        n.end_of_balance_flag    = 1'b1;
        n.run    = 1'b0;
        n.phase  = cbs_pkg::PH_IDLE;
        n.cnt    = 7'h0;
        tick_clr = 1'b1;
      end
    end

    // ****************************************
    // switch drive
    // ****************************************
    if (n.sleep || !n.run) begin
      n.cb = 12'h0;
    end else begin
      case (n.mode)
        `CBS_MODE_MAN: begin
          n.cb = n.pat[0];
        end
        `CBS_MODE_TIMED: begin
          n.cb = (n.phase == cbs_pkg::PH_ON) ?
                 n.pat[0] : 12'h0;
        end
        `CBS_MODE_AUTO: begin
          n.cb = (n.phase == cbs_pkg::PH_ON) ?
                 n.pat[n.apt] & nz : 12'h0;
        end
        default: begin
          n.cb = 12'h0;
        end
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      s <= `CBS_RESET_ALL;
    end else if (CE_I) begin
      s <= n;
    end
  end

endmodule : cbs_seq

// *** test/cbs_seq_assertions.sv ***
// port checker of the cell balance sequencer
`include "cbs_consts.svh"
module cbs_seq_assertions #(
  parameter int unsigned TICK_CYC = 4
) (
  input wire logic        MCLK_I,
  input wire logic        RST_I,
  input wire logic        CE_I,
  input wire logic        WR_I,
  input wire logic        RD_I,
  input wire logic [5:0]  ADDR_I,
  input wire logic [13:0] WDATA_I,
  input wire logic        CMD_INH_I,
  input wire logic        CMD_SLEEP_I,
  input wire logic        CMD_WAKE_I,
  input wire logic        WDT_EXP_I,
  input wire logic [11:0] CB_O,
  input wire logic        SCAN_REQ_O,
  input wire logic        SLEEP_O,
  input wire logic [13:0] RDATA_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wdt_on_reg;
  default clocking dc @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  // ****************************************
  // watchdog field shadow
  // ****************************************
  always_ff @(posedge MCLK_I) begin
    if (RST_I) wdt_on_reg <= 1'h0;
    else if (CE_I && WR_I && ADDR_I == `CBS_A_WDBT) wdt_on_reg <= |WDATA_I[6:0];
  end
  a_sleep_quiet: assert property (SLEEP_O |-> CB_O == '0)
    else $error("cells driven in sleep");
  a_sleep_cmd: assert property (
    CE_I && CMD_SLEEP_I |=> SLEEP_O && CB_O == '0)
    else $error("sleep command left cells on");
  a_inhibit_off: assert property (CE_I && CMD_INH_I |=> CB_O == '0)
    else $error("inhibit left cells on");
  a_wdt_sleep: assert property (
    CE_I && WDT_EXP_I && wdt_on_reg |=> SLEEP_O && CB_O == '0)
    else $error("watchdog expiry did not stop");
  a_wake_only: assert property (
    $fell(SLEEP_O) && !$past(RST_I) |-> $past(CE_I && CMD_WAKE_I))
    else $error("sleep left without wake");
  a_wake_clear: assert property (
    CE_I && CMD_WAKE_I && !CMD_SLEEP_I && !WDT_EXP_I |=> !SLEEP_O)
    else $error("wake did not leave sleep");
  a_scan_pulse: assert property (
    SCAN_REQ_O |-> CB_O == '0 ##1 !SCAN_REQ_O)
    else $error("scan request malformed");
  a_active_read: assert property (
    CE_I && RD_I && ADDR_I == `CBS_A_ACTIVE |=> RDATA_O == {2'h0, $past(CB_O)})
    else $error("active cells read wrong");
  cover property (SCAN_REQ_O);
  cover property ($fell(SLEEP_O));
  cover property (CE_I && WDT_EXP_I && wdt_on_reg);
endmodule : cbs_seq_assertions

bind cbs_seq cbs_seq_assertions #(.TICK_CYC(TICK_CYC)) u_chk (
  .MCLK_I(MCLK_I), .RST_I(RST_I), .CE_I(CE_I), .WR_I(WR_I), .RD_I(RD_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .CMD_INH_I(CMD_INH_I),
  .CMD_SLEEP_I(CMD_SLEEP_I), .CMD_WAKE_I(CMD_WAKE_I), .WDT_EXP_I(WDT_EXP_I),
  .CB_O(CB_O), .SCAN_REQ_O(SCAN_REQ_O), .SLEEP_O(SLEEP_O), .RDATA_O(RDATA_O)
);

// *** test/cbs_scan_model.sv ***
// scan and measurement source facing the sequencer
module cbs_scan_model (
  input  wire logic        clk_i,
  input  wire logic        req_i,
  input  wire logic        slow_i,
  input  wire logic [13:0] data_i,
  output logic             done_o,
  output logic             valid_o,
  output logic [3:0]       cell_o,
  output logic [13:0]      meas_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // one full scan per request
  // ****************************************
  initial begin
    done_o = 1'h0;
    valid_o = 1'h0;
    cell_o = 4'hf;
    meas_o = 14'h0000;
    forever begin
      @(negedge clk_i);
      if (req_i) begin
        if (slow_i) repeat (7) @(negedge clk_i);
        for (int c = 0; c < 12; c++) begin
          valid_o <= 1'h1;
          cell_o <= 4'(c);
          meas_o <= data_i;
          @(negedge clk_i);
        end
        valid_o <= 1'h0;
        cell_o <= ~cell_o;
        meas_o <= ~data_i;
        done_o <= 1'h1;
        @(negedge clk_i);
        done_o <= 1'h0;
      end
    end
  end
endmodule : cbs_scan_model

// *** test/test_cell_balance_sequencer.sv ***
// self-checking bench of the cell balance sequencer
`include "cbs_consts.svh"
module test_cell_balance_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TC = 4;
  localparam int MD = 16;
  logic        mclk = 1'h0;
  logic        rst = 1'h1;
  logic        wr = 1'h0;
  logic        rd = 1'h0;
  logic        slow = 1'h0;
  logic        ce = 1'h1;
  logic [4:0]  cmd = '0;
  logic [5:0]  addr = '0;
  logic [13:0] wdata = '0;
  logic [13:0] rdat, md;
  logic [11:0] cb, p, g, em;
  logic        sl, sreq, done, mv;
  logic [3:0]  mc;
  int          mismatches = 0;
  int          n_compared = 0;
  int          pat[13];
  int          val[12];
  int          loc, nl, k;
  always #20 mclk = ~mclk;
  cbs_seq #(.TICK_CYC(TC)) dut (
    .MCLK_I(mclk), .RST_I(rst), .CE_I(ce), .WR_I(wr), .RD_I(rd),
    .ADDR_I(addr), .WDATA_I(wdata), .CMD_EN_I(cmd[0]), .CMD_INH_I(cmd[1]),
    .CMD_SLEEP_I(cmd[2]), .CMD_WAKE_I(cmd[3]), .WDT_EXP_I(cmd[4]),
    .SCAN_DONE_I(done), .MEAS_VALID_I(mv), .MEAS_CELL_I(mc),
    .MEAS_DATA_I(md), .CB_O(cb), .SCAN_REQ_O(sreq), .SLEEP_O(sl),
    .RDATA_O(rdat)
  );
  cbs_scan_model pm (
    .clk_i(mclk), .req_i(sreq), .slow_i(slow), .data_i(14'(MD)),
    .done_o(done), .valid_o(mv), .cell_o(mc), .meas_o(md)
  );
  // ****************************************
  // helpers
  // ****************************************
  task automatic report_and_stop;
    if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task automatic bad(string s);
    mismatches++;
    $display("mismatch %0t %s", $time, s);
  endtask : bad
  task automatic cyc(int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  task automatic chk_cb(logic [11:0] a, logic [11:0] e);
    n_compared++;
    if (a !== e) bad("cell drives");
  endtask : chk_cb
  task automatic chk_rd(logic [13:0] a, logic [13:0] e);
    n_compared++;
    if (a !== e) bad("register read");
  endtask : chk_rd
  task automatic chk_sl(logic e);
    n_compared++;
    if (sl !== e) bad("sleep state");
  endtask : chk_sl
  task automatic wreg(logic [5:0] a, logic [13:0] d);
    addr = a;
    wdata = d;
    wr = 1'h1;
    cyc(1);
    wr = 1'h0;
    cyc(1);
  endtask : wreg
  task automatic rreg(logic [5:0] a, logic [13:0] e);
    addr = a;
    rd = 1'h1;
    cyc(1);
    rd = 1'h0;
    chk_rd(rdat, e);
    cyc(1);
  endtask : rreg
  task automatic pulse(int n);
    cmd[n] = 1'h1;
    cyc(1);
    cmd[n] = 1'h0;
    cyc(1);
  endtask : pulse
  function automatic logic [13:0] su(logic r, logic [3:0] l, logic [1:0] m);
    return {3'h0, r, 4'h1, l, m};
  endfunction : su
  task automatic setpat(int l, logic [11:0] v, logic [1:0] m);
    wreg(`CBS_A_SETUP, su(1'h0, 4'(l), m));
    wreg(`CBS_A_PATTERN, {2'h0, v});
    pat[l] = int'(v);
  endtask : setpat
  function automatic logic [11:0] nz();
    for (int c = 0; c < 12; c++) nz[c] = val[c] != 0;
  endfunction : nz
  task automatic wait_ev(int n, output logic [11:0] o);
    logic [11:0] pv;
    pv = cb;
    for (int i = 0; i < 300; i++) begin
      cyc(1);
      if (n ? done : sreq) begin
        o = pv;
        return;
      end
      pv = cb;
    end
    bad("no scan event");
    o = pv;
  endtask : wait_ev
  initial begin
    #200us;
    bad("timeout");
    report_and_stop;
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    void'($urandom(38982));
    cyc(8);
    rst = 1'h0;
    rreg(`CBS_A_WDBT, 14'h0000);
    rreg(6'h3f, 14'h0000);
    p = 12'($urandom) | 12'h001;
    setpat(0, p, `CBS_MODE_TIMED);
    wreg(`CBS_A_WDBT, {7'h02, 7'h00});
    wreg(`CBS_A_SETUP, su(1'h1, 4'h0, `CBS_MODE_TIMED));
    cyc(2 * TC - 3);
    chk_cb(cb, p);
    cyc(3);
    chk_cb(cb, 12'h000);
    rreg(`CBS_A_DEVSET, 14'h0001);
    rreg(`CBS_A_SETUP, su(1'h0, 4'h0, `CBS_MODE_TIMED));
    pulse(0);
    chk_cb(cb, p);
    cyc(4);
    pulse(0);
    cyc(4);
    chk_cb(cb, p);
    pulse(1);
    chk_cb(cb, 12'h000);
    pulse(0);
    pulse(2);
    chk_cb(cb, 12'h000);
    chk_sl(1'h1);
    pulse(3);
    chk_cb(cb, p);
    pulse(2);
    cyc(3 * TC);
    pulse(3);
    chk_cb(cb, 12'h000);
    wreg(`CBS_A_DEVSET, 14'h0000);
    wreg(`CBS_A_WDBT, 14'h0005);
    pulse(0);
    cyc(3 * TC);
    chk_cb(cb, p);
    rreg(`CBS_A_ACTIVE, {2'h0, p});
    ce = 1'h0;
    pulse(1);
    chk_cb(cb, p);
    ce = 1'h1;
    pulse(4);
    chk_cb(cb, 12'h000);
    chk_sl(1'h1);
    rreg(`CBS_A_DEVSET, 14'h0002);
    pulse(1);
    pulse(3);
    chk_sl(1'h0);
    wreg(`CBS_A_WDBT, {7'h01, 7'h00});
    wreg(`CBS_A_DEVSET, 14'h0000);
    nl = 1 + $urandom % 3;
    for (int l = 1; l <= 4; l++) begin
      setpat(l, l > nl ? 12'h000 : 12'($urandom) | 12'h001, `CBS_MODE_AUTO);
    end
    for (int c = 0; c < 12; c++) begin
      val[c] = (pat[1] | pat[2] | pat[3]) >> c & 1 ? MD * (1 + $urandom % 3) : 0;
      wreg(6'(32 + 2 * c), 14'(val[c]));
    end
    pulse(0);
    loc = 1;
    k = 0;
    while (val.sum() != 0 && k < 40) begin
      slow = 1'($urandom);
      em = 12'(pat[loc]) & nz();
      wait_ev(0, g);
      chk_cb(g, em);
      for (int c = 0; c < 12; c++) begin
        if (em[c]) val[c] = val[c] > MD ? val[c] - MD : 0;
      end
      loc = loc == 12 || pat[loc + 1] == 0 ? 1 : loc + 1;
      if (k == 1 && val.sum() != 0) begin
        wait_ev(1, g);
        pulse(1);
        pulse(0);
        loc = 1;
      end
      k++;
    end
    wait_ev(1, g);
    cyc(TC);
    chk_cb(cb, 12'h000);
    rreg(`CBS_A_DEVSET, 14'h0001);
    report_and_stop;
  end
endmodule : test_cell_balance_sequencer
